/* core/sdc_map.vh */
/*
  Register offsets, field positions, reset values and timing counts for the
  sigma-delta converter digital core. Assumes inclusion by bare name.
*/
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SDC_CTL_ADDR 12'h000
`define SDC_CCTL_ADDR 12'h004
`define SDC_INCTL_ADDR 12'h008
`define SDC_AE_ADDR 12'h00C
`define SDC_RESULT_ADDR 12'h010
`define SDC_STATUS_ADDR 12'h014

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SDC_CTL_REFON 2
`define SDC_CTL_VMID 3
`define SDC_CTL_SSEL_LO 4
`define SDC_CTL_DIV_LO 6
`define SDC_CTL_XDIV_LO 9

// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define SDC_CC_SC 1
`define SDC_CC_IFG 2
`define SDC_CC_DF 4
`define SDC_CC_OVIFG 5
`define SDC_CC_LSBACC 6
`define SDC_CC_LSBTOG 7
`define SDC_CC_OSR_LO 8
`define SDC_CC_SNGL 10
`define SDC_CC_XOSR 11
`define SDC_CC_UNI 12
`define SDC_CC_BUF_LO 13

// ----------------------------------------
// Input control fields
// ----------------------------------------
`define SDC_IN_INCH_LO 0
`define SDC_IN_GAIN_LO 3
`define SDC_IN_DLY_LO 6

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SDC_CTL_RST 16'h0000
`define SDC_CCTL_RST 16'h0000
`define SDC_INCTL_RST 16'h0000
`define SDC_AE_RST 8'h00
`define SDC_SETTLE_RESULTS 3'd4
`define SDC_GAIN_MAX 3'd5

`endif

/* core/sdc_adc_core.v */
/*
  Digital core of a single-channel sigma-delta converter: APB register file,
  modulator clock enable, third-order comb decimator, result formatting and
  conversion control. Assumes the analog modulator returns one bit per
  modulator enable pulse on modBit, from outside this clock domain.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.vh"

module sdc_adc_core #(
  parameter ACC_W = 31
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Modulator clock sources
  input wire subMainClkEn,
  input wire auxClkEn,
  input wire extClkEn,
  // Modulator
  input wire modBit,
  output reg modEnable,
  output reg modSampleEn,
  output reg [2:0] inputPairSel,
  output reg [2:0] pgaGainSel,
  output reg [1:0] inputBufferMode,
  // Reference and pins
  output reg referenceEnable,
  output reg refBufferOutEnable,
  output reg [7:0] analogPinEnable,
  // Event lines
  output reg resultEvent,
  output reg irqRequest
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] ctlReg;
  reg [15:0] cctlReg;
  reg [15:0] inctlReg;
  reg [2:0] inchAct_reg;
  reg [2:0] gainAct_reg;
  reg [1:0] syncA_reg;
  reg [1:0] syncB_reg;
  reg [1:0] syncC_reg;
  reg [1:0] modSync_reg;
  reg [5:0] divCnt_reg;
  reg [10:0] sampCnt_reg;
  reg [ACC_W-1:0] int1_reg;
  reg [ACC_W-1:0] int2_reg;
  reg [ACC_W-1:0] int3_reg;
  reg [ACC_W-1:0] d1_reg;
  reg [ACC_W-1:0] d2_reg;
  reg [ACC_W-1:0] d3_reg;
  reg [ACC_W-1:0] filtOut_reg;
  reg [2:0] settleCnt_reg;
  reg unread_reg;
  reg running_reg;
  wire [1:0] ssel = ctlReg[`SDC_CTL_SSEL_LO +: 2];
  wire [1:0] divSel = ctlReg[`SDC_CTL_DIV_LO +: 2];
  wire [2:0] xdivSel = ctlReg[`SDC_CTL_XDIV_LO +: 3];
  wire [1:0] osrSel = cctlReg[`SDC_CC_OSR_LO +: 2];
  wire xosr = cctlReg[`SDC_CC_XOSR];
  wire startBit = cctlReg[`SDC_CC_SC];
  wire [2:0] dlySel = inctlReg[`SDC_IN_DLY_LO +: 3];

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Ratio: 256,128,64,32 or, extended, 512,1024 (codes 2/3 unused -> 1024).
  function [10:0] osrOf;
    input [1:0] sel;
    input x;
    begin
      if (x) begin
        osrOf = (sel == 2'd0) ? 11'h200 : 11'h400;
      end else begin
        case (sel)
          2'd0: osrOf = 11'h100;
          2'd1: osrOf = 11'h080;
          2'd2: osrOf = 11'h040;
          default: osrOf = 11'h020;
        endcase
      end
    end
  endfunction

  // Log2 of ratio gives output width 3*log2 (15 to 30 bits).
  function [3:0] lgOf;
    input [10:0] r;
    begin
      case (r)
        11'h020: lgOf = 4'd5;
        11'h040: lgOf = 4'd6;
        11'h080: lgOf = 4'd7;
        11'h100: lgOf = 4'd8;
        11'h200: lgOf = 4'd9;
        default: lgOf = 4'd10;
      endcase
    end
  endfunction

  // Divider terminal count: product of the factors decoded from the two divider fields minus one, capped at 63.
  function [5:0] divOf;
    input [1:0] d;
    input [2:0] x;
    reg [5:0] a;
    reg [5:0] b;
    begin
      a = 6'd1 << d;
      case (x)
        3'd1: b = 6'd3;
        3'd2: b = 6'd16;
        3'd3: b = 6'd48;
        default: b = 6'd1;
      endcase
      divOf = ({6'd0, a} * {6'd0, b} > 12'd64) ? 6'h3F : a * b - 6'd1;
    end
  endfunction

  wire [10:0] osr = osrOf(osrSel, xosr);
  wire [3:0] lg = lgOf(osr);
  wire [4:0] outW = {1'b0, lg} * 5'd3;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg <= 2'b00;
      syncB_reg <= 2'b00;
      syncC_reg <= 2'b00;
      modSync_reg <= 2'b00;
    end else begin
      syncA_reg <= {syncA_reg[0], subMainClkEn};
      syncB_reg <= {syncB_reg[0], auxClkEn};
      syncC_reg <= {syncC_reg[0], extClkEn};
      modSync_reg <= {modSync_reg[0], modBit};
    end
  end

  // ----------------------------------------
  // Modulator clock enable
  // ----------------------------------------
  reg srcEn;
  always @* begin
    case (ssel)
      2'd0: srcEn = 1'b1;
      2'd1: srcEn = syncA_reg[1];
      2'd2: srcEn = syncB_reg[1];
      default: srcEn = syncC_reg[1];
    endcase
  end

  wire modTick = running_reg && srcEn && (divCnt_reg == divOf(divSel, xdivSel));
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_reg <= 6'd0;
    end else if (!running_reg) begin
      divCnt_reg <= 6'd0;
    end else if (srcEn) begin
      divCnt_reg <= modTick ? 6'd0 : divCnt_reg + 6'd1;
    end
  end

  // ----------------------------------------
  // Third-order comb decimator
  // ----------------------------------------
  // Width 31 holds 3*10 bits plus sign headroom; modular arithmetic cancels wrap.
  wire [ACC_W-1:0] bitIn = {{(ACC_W-1){1'b0}}, modSync_reg[1]};
  wire [ACC_W-1:0] int1Next = int1_reg + bitIn;
  wire [ACC_W-1:0] int2Next = int2_reg + int1Next;
  wire [ACC_W-1:0] int3Next = int3_reg + int2Next;
  wire decim = modTick && (sampCnt_reg == osr - 11'd1);
  wire [ACC_W-1:0] c1 = int3Next - d1_reg;
  wire [ACC_W-1:0] c2 = c1 - d2_reg;
  wire [ACC_W-1:0] c3 = c2 - d3_reg;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sampCnt_reg <= 11'd0;
      int1_reg <= {ACC_W{1'b0}};
      int2_reg <= {ACC_W{1'b0}};
      int3_reg <= {ACC_W{1'b0}};
      d1_reg <= {ACC_W{1'b0}};
      d2_reg <= {ACC_W{1'b0}};
      d3_reg <= {ACC_W{1'b0}};
      filtOut_reg <= {ACC_W{1'b0}};
    end else if (!running_reg) begin
      // Filter state is held cleared while powered down; filtOut_reg keeps the last result
      sampCnt_reg <= 11'd0;
      int1_reg <= {ACC_W{1'b0}};
      int2_reg <= {ACC_W{1'b0}};
      int3_reg <= {ACC_W{1'b0}};
      d1_reg <= {ACC_W{1'b0}};
      d2_reg <= {ACC_W{1'b0}};
      d3_reg <= {ACC_W{1'b0}};
    end else if (modTick) begin
      int1_reg <= int1Next;
      int2_reg <= int2Next;
      int3_reg <= int3Next;
      sampCnt_reg <= decim ? 11'd0 : sampCnt_reg + 11'd1;
      if (decim) begin
        d1_reg <= int3Next;
        d2_reg <= c1;
        d3_reg <= c2;
        filtOut_reg <= c3;
      end
    end
  end

  // ----------------------------------------
  // Result formatting
  // ----------------------------------------
  // Full scale equals osr^3; shift so the top 16 bits align, unipolar one lower.
  wire uni = cctlReg[`SDC_CC_UNI];
  wire [ACC_W-1:0] bip = filtOut_reg - ({{(ACC_W-1){1'b0}}, 1'b1} << (outW - 5'd1));
  wire [ACC_W-1:0] sel = uni ? bip : filtOut_reg;
  wire [4:0] hiShift = uni ? outW - 5'd17 : outW - 5'd16;
  wire [ACC_W-1:0] shifted = (outW >= 5'd17) ? (sel >> hiShift) : (sel << (5'd0 - hiShift));
  // Unipolar negative inputs clip to zero.
  wire [15:0] upper = (uni && bip[ACC_W-1]) ? 16'h0000 : shifted[15:0];
  wire [15:0] fmtHi = cctlReg[`SDC_CC_DF] && !uni ? {~upper[15], upper[14:0]} : upper;
  wire [15:0] resultWord = cctlReg[`SDC_CC_LSBACC] ? filtOut_reg[15:0] : fmtHi;

  // ----------------------------------------
  // APB access decode
  // ----------------------------------------
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rdResult = acc && !pwrite && (paddr == `SDC_RESULT_ADDR);
  wire byteRead = (pstrb == 4'h1) || (paddr[1:0] != 2'b00);
  wire wrCctl = wr && (paddr == `SDC_CCTL_ADDR);
  wire wrIn = wr && (paddr == `SDC_INCTL_ADDR);
  wire mapped = (paddr == `SDC_CTL_ADDR) || (paddr == `SDC_CCTL_ADDR)
    || (paddr == `SDC_INCTL_ADDR) || (paddr == `SDC_AE_ADDR)
    || (paddr == `SDC_RESULT_ADDR) || (paddr == `SDC_STATUS_ADDR);
  wire startRise = wrCctl && pwdata[`SDC_CC_SC] && !startBit;
  wire inChange = wrIn && (pwdata[5:0] != inctlReg[5:0]);
  wire gainOk = pwdata[`SDC_IN_GAIN_LO +: 3] <= `SDC_GAIN_MAX;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SDC_CTL_ADDR: prdata <= {16'h0000, ctlReg};
          `SDC_CCTL_ADDR: prdata <= {16'h0000, cctlReg};
          `SDC_INCTL_ADDR: prdata <= {16'h0000, inctlReg};
          `SDC_AE_ADDR: prdata <= {24'h00_0000, analogPinEnable};
          `SDC_RESULT_ADDR: prdata <= byteRead ? {24'h00_0000, filtOut_reg[7:0]}
            : {16'h0000, resultWord};
          `SDC_STATUS_ADDR: prdata <= {28'h000_0000, running_reg, settleCnt_reg[2:0]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers and conversion control
  // ----------------------------------------
  wire singleDone = decim && cctlReg[`SDC_CC_SNGL];
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctlReg <= `SDC_CTL_RST;
      cctlReg <= `SDC_CCTL_RST;
      inctlReg <= `SDC_INCTL_RST;
      analogPinEnable <= `SDC_AE_RST;
      inchAct_reg <= 3'd0;
      gainAct_reg <= 3'd0;
      settleCnt_reg <= 3'd0;
      unread_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      if (wr && paddr == `SDC_CTL_ADDR) begin
        ctlReg <= {4'h0, pwdata[11:1], 1'b0};
      end
      if (wr && paddr == `SDC_AE_ADDR) begin
        analogPinEnable <= pwdata[7:0];
      end
      if (wrIn) begin
        inctlReg <= {7'h00, pwdata[8:6], gainOk ? pwdata[5:3] : inctlReg[5:3], pwdata[2:0]};
      end
      if (wrCctl) begin
        // Writing the toggle bit itself never moves low access
        cctlReg <= {1'b0, pwdata[14:8], pwdata[7], pwdata[6],
          pwdata[5] & cctlReg[5], pwdata[4], pwdata[3],
          pwdata[2] & cctlReg[2], pwdata[1], 1'b0};
      end
      if (rdResult) begin
        cctlReg[`SDC_CC_IFG] <= 1'b0;
        if (cctlReg[`SDC_CC_LSBTOG]) begin
          cctlReg[`SDC_CC_LSBACC] <= ~cctlReg[`SDC_CC_LSBACC];
        end
      end
      if (singleDone) begin
        cctlReg[`SDC_CC_SC] <= 1'b0;
      end
      // New result wins over a same-cycle clear
      if (decim) begin
        cctlReg[`SDC_CC_IFG] <= 1'b1;
        if (unread_reg && !rdResult) begin
          cctlReg[`SDC_CC_OVIFG] <= 1'b1;
        end
      end
      if (decim) begin
        unread_reg <= 1'b1;
      end else if (rdResult) begin
        unread_reg <= 1'b0;
      end
      // Pair and gain reach the analog side while stopped, and only at decimation while running
      if (!running_reg || decim) begin
        inchAct_reg <= inctlReg[2:0];
        gainAct_reg <= inctlReg[5:3];
      end
      running_reg <= wrCctl ? pwdata[`SDC_CC_SC] : (startBit && !singleDone);
      if (startRise || (running_reg && inChange)) begin
        settleCnt_reg <= (dlySel == 3'd0) ? `SDC_SETTLE_RESULTS : 3'd4 - dlySel[1:0];
      end else if (decim && settleCnt_reg != 3'd0) begin
        settleCnt_reg <= settleCnt_reg - 3'd1;
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      modEnable <= 1'b0;
      modSampleEn <= 1'b0;
      inputPairSel <= 3'd0;
      pgaGainSel <= 3'd0;
      inputBufferMode <= 2'd0;
      referenceEnable <= 1'b0;
      refBufferOutEnable <= 1'b0;
      resultEvent <= 1'b0;
      irqRequest <= 1'b0;
    end else begin
      modEnable <= running_reg;
      modSampleEn <= modTick;
      inputPairSel <= inchAct_reg;
      pgaGainSel <= gainAct_reg;
      inputBufferMode <= cctlReg[`SDC_CC_BUF_LO +: 2];
      referenceEnable <= ctlReg[`SDC_CTL_REFON];
      refBufferOutEnable <= ctlReg[`SDC_CTL_VMID];
      resultEvent <= decim;
      // Settling results give no request; counter hits zero on the 4th at delay code zero
      irqRequest <= decim && (settleCnt_reg <= 3'd1);
    end
  end

endmodule // sdc_adc_core
`default_nettype wire

/* testbench/sdc_adc_core_sva.sv */
/*
  Port-level checker for the converter core: APB answer timing, power and
  result event behaviour. Assumes binding to sdc_adc_core, ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_adc_core_sva (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Converter events
  input wire modEnable,
  input wire modSampleEn,
  input wire resultEvent,
  input wire irqRequest
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside one access cycle");
  chk_error_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  // ----------------------------------------
  // Conversion
  // ----------------------------------------
  // One cycle of slack: the sample strobe is registered in the same cycle as the power level and never lags it
  chk_sample_power: assert property (modSampleEn |-> modEnable || $past(modEnable))
    else $error("sample while powered down");
  chk_stop_quiet: assert property (!modEnable && !$past(modEnable) |-> !resultEvent)
    else $error("result while stopped");
  chk_result_spacing: assert property (resultEvent |=> !resultEvent [*8])
    else $error("results too close");
  chk_irq_result: assert property (irqRequest |-> resultEvent || $past(resultEvent))
    else $error("request without result");
  chk_irq_pulse: assert property ($rose(irqRequest) |=> !irqRequest)
    else $error("request longer than a pulse");
endmodule // sdc_adc_core_sva

bind sdc_adc_core sdc_adc_core_sva chkInst (.core_clk, .resetn, .psel, .penable, .prdata,
  .pready, .pslverr, .modEnable, .modSampleEn, .resultEvent, .irqRequest);
`default_nettype wire

/* testbench/sigma_delta_adc_digital_core_tb.sv */
/*
  Self-checking bench for the converter core: APB register tasks and call
  sequences. Assumes sdc_map.vh on the include path, checker bound.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sdc_map.vh"
module sigma_delta_adc_digital_core_tb;
  localparam logic [31:0] SC = 32'h0000_0001 << `SDC_CC_SC;
  localparam logic [31:0] IFG = 32'h0000_0001 << `SDC_CC_IFG;
  localparam logic [31:0] DF = 32'h0000_0001 << `SDC_CC_DF;
  localparam logic [31:0] OV = 32'h0000_0001 << `SDC_CC_OVIFG;
  localparam logic [31:0] LACC = 32'h0000_0001 << `SDC_CC_LSBACC;
  localparam logic [31:0] LTOG = 32'h0000_0001 << `SDC_CC_LSBTOG;
  localparam logic [31:0] SNGL = 32'h0000_0001 << `SDC_CC_SNGL;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic core_clk, resetn, psel, penable, pwrite, rerr;
  logic modBit = 1'b0;
  logic subEn = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [3:0] pstrb;
  wire [31:0] prdata;
  wire pready, pslverr, modEnable, modSampleEn, resultEvent, irqRequest;
  wire referenceEnable, refBufferOutEnable;
  wire [2:0] inputPairSel, pgaGainSel;
  wire [1:0] inputBufferMode;
  wire [7:0] analogPinEnable;
  int n_fail, comparisons, nRes, nSamp, lastSamp, gap, firstIrq, nIrq, r, i;

  sdc_adc_core uut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .subMainClkEn(subEn), .auxClkEn(1'b0),
    .extClkEn(1'b0), .modBit(modBit), .modEnable(modEnable), .modSampleEn(modSampleEn),
    .inputPairSel(inputPairSel), .pgaGainSel(pgaGainSel), .inputBufferMode(inputBufferMode),
    .referenceEnable(referenceEnable), .refBufferOutEnable(refBufferOutEnable),
    .analogPinEnable(analogPinEnable), .resultEvent(resultEvent), .irqRequest(irqRequest));

  // ----------------------------------------
  // Clock, modulator stream and monitors
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Alternating bits mean zero input, so settled results are exactly mid-scale
  always @(posedge core_clk) begin
    if (modSampleEn === 1'b1) modBit <= ~modBit;
  end
  // Half-rate enable for the sub-main source
  always @(posedge core_clk) begin
    subEn <= ~subEn;
  end
  always @(posedge core_clk) begin
    if (modSampleEn === 1'b1) nSamp++;
    if (resultEvent === 1'b1) begin
      nRes++;
      gap = nSamp - lastSamp;
      lastSamp = nSamp;
    end
    if (irqRequest === 1'b1 && firstIrq == 0) firstIrq = nRes;
    if (irqRequest === 1'b1) nIrq++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    chk(pready, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rdat & m, e);
  endtask
  task automatic waitRes(input int n);
    int k;
    k = 0;
    while (nRes < n && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #600000;
    n_fail++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {resetn, psel, penable, pwrite} = 4'b0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`SDC_CTL_ADDR, ALL, 32'h0000_0000);
    rd(`SDC_CCTL_ADDR, ALL, 32'h0000_0000);
    rd(`SDC_INCTL_ADDR, ALL, 32'h0000_0000);
    rd(`SDC_AE_ADDR, ALL, 32'h0000_0000);
    rd(12'h018, ALL, 32'h0000_0000);
    chk(rerr, 32'h0000_0001);
    wr(`SDC_CTL_ADDR, 32'h0000_000C);
    chk({referenceEnable, refBufferOutEnable}, 32'h0000_0003);
    wr(`SDC_AE_ADDR, 32'h0000_00A5);
    chk(analogPinEnable, 32'h0000_00A5);
    for (i = 0; i < 4; i++) begin
      wr(`SDC_CCTL_ADDR, i << `SDC_CC_BUF_LO);
      chk(inputBufferMode, i);
    end
    for (i = 0; i < 8; i++) begin
      wr(`SDC_INCTL_ADDR, i << `SDC_IN_INCH_LO);
      chk(inputPairSel, i);
    end
    for (i = 0; i < 7; i++) begin
      wr(`SDC_INCTL_ADDR, i << `SDC_IN_GAIN_LO);
      chk(pgaGainSel, (i > 5) ? 5 : i);
    end
    // Continuous run, ratio 256, delay code zero
    wr(`SDC_INCTL_ADDR, 32'h0000_0000);
    wr(`SDC_CCTL_ADDR, SC);
    chk(modEnable, 32'h0000_0001);
    waitRes(5);
    chk(firstIrq, 4);
    chk(gap, 256);
    rd(`SDC_CCTL_ADDR, IFG | OV, IFG | OV);
    rd(`SDC_RESULT_ADDR, ALL, 32'h0000_8000);
    xfer(1'b0, `SDC_RESULT_ADDR, 32'h0000_0000, 4'h1);
    chk(rdat, 32'h0000_0000);
    rd(`SDC_CCTL_ADDR, IFG, 32'h0000_0000);
    wr(`SDC_CCTL_ADDR, SC | DF);
    rd(`SDC_CCTL_ADDR, OV, 32'h0000_0000);
    waitRes(nRes + 2);
    rd(`SDC_RESULT_ADDR, ALL, 32'h0000_0000);
    wr(`SDC_CCTL_ADDR, SC | LACC);
    waitRes(nRes + 1);
    rd(`SDC_RESULT_ADDR, ALL, 32'h0000_0000);
    wr(`SDC_CCTL_ADDR, SC | LTOG);
    rd(`SDC_CCTL_ADDR, LACC, 32'h0000_0000);
    rd(`SDC_RESULT_ADDR, ALL, 32'h0000_8000);
    rd(`SDC_RESULT_ADDR, ALL, 32'h0000_0000);
    rd(`SDC_RESULT_ADDR, ALL, 32'h0000_8000);
    // Pair change mid-run holds until the next decimation
    xfer(1'b1, `SDC_INCTL_ADDR, 32'h0000_0003, 4'hF);
    repeat (3) @(posedge core_clk);
    chk(inputPairSel, 32'h0000_0000);
    waitRes(nRes + 1);
    repeat (2) @(posedge core_clk);
    chk(inputPairSel, 32'h0000_0003);
    wr(`SDC_CCTL_ADDR, 32'h0000_0000);
    chk(modEnable, 32'h0000_0000);
    r = nRes;
    repeat (600) @(posedge core_clk);
    chk(nRes, r);
    chk(referenceEnable, 32'h0000_0001);
    wr(`SDC_CTL_ADDR, 32'h0000_0000);
    chk(referenceEnable, 32'h0000_0000);
    // Sub-main source at half rate, divider two: one sample every four cycles
    wr(`SDC_CTL_ADDR, 32'h0000_0050);
    wr(`SDC_CCTL_ADDR, SC);
    @(negedge core_clk);
    r = nSamp;
    repeat (100) @(negedge core_clk);
    chk(nSamp - r, 25);
    wr(`SDC_CCTL_ADDR, 32'h0000_0000);
    wr(`SDC_CTL_ADDR, 32'h0000_0000);
    // Single conversion at ratio 32, delay code three: request on first result
    wr(`SDC_INCTL_ADDR, 32'h0000_00C0);
    r = nIrq;
    wr(`SDC_CCTL_ADDR, SC | SNGL | 32'h0000_0300);
    waitRes(nRes + 1);
    repeat (3) @(posedge core_clk);
    rd(`SDC_CCTL_ADDR, SC, 32'h0000_0000);
    chk(modEnable, 32'h0000_0000);
    chk(nIrq - r, 1);
    rd(`SDC_RESULT_ADDR, 32'h0000_0001, 32'h0000_0000);
    results();
  end
endmodule // sigma_delta_adc_digital_core_tb
`default_nettype wire
